// ==== rtl/tlv_arbiter.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlv_arbiter #(
  parameter int N = 22,
  parameter int W = 5
) (
  input  wire logic [N-1:0] req_vec,
  output logic              found,
  output logic [W-1:0]      win_idx
);
  // The lowest order wins, so the scan runs downward and the last hit stays.
  always_comb begin
    found   = 1'b0;
    win_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        found   = 1'b1;
        win_idx = W'(i);
      end
    end
  end
endmodule : tlv_arbiter
`default_nettype wire

// ==== rtl/tlv_ext_input.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlv_ext_input (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin_n,
  input  wire logic trig_edge,
  input  wire logic vec_clear,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      flag
);
  logic prev_pin_reg;  // Pin level of the last cycle, for the falling edge.
  logic flag_reg;      // The pending flag itself.
  logic fall;          // A falling edge seen this cycle.
  logic flag_next;     // Next value of the flag.

  assign fall = prev_pin_reg & ~pin_n;
  // Edge mode latches, a set beats both clears; level mode follows the pin.
  assign flag_next = trig_edge ?
                     (fall | (sw_wr ? sw_val : (flag_reg & ~vec_clear))) :
                     ~pin_n;
  assign flag = flag_reg;

  // Both flops reset to idle: pin high, flag clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_pin_reg <= 1'b1;
      flag_reg     <= 1'b0;
    end else begin
      prev_pin_reg <= pin_n;
      flag_reg     <= flag_next;
    end
  end

  AST_LEVEL_TRACKS: assert property (@(posedge clk) disable iff (!nrst)
    $past(!trig_edge) |-> (flag_reg == !$past(pin_n)))
    else $error("Level mode flag does not follow the pin.");
  AST_EDGE_LATCH: assert property (@(posedge clk) disable iff (!nrst)
    (trig_edge && fall) |=> flag_reg)
    else $error("Falling edge did not set the flag.");
endmodule : tlv_ext_input
`default_nettype wire

// ==== rtl/tlv_irq_unit.sv ====
// How it works
// - Twenty-two sources, each low or high priority.
// - Trigger sets pending flag even when disabled.
// - Disabled source pending flag raises no request.
// - Core vectors after current instruction completes.
// - Return resumes at the interrupted next instruction.
// - Global enable off blocks every source.
// - Every source has its own enable bit.
// - Flag still set after return re-enters later.
// - Software-set flag acts like hardware-set flag.
// - Only timers, edge inputs, CAN cleared on vectoring.
// - External inputs active low, level or edge.
// - Edge mode external flag cleared on vectoring.
// - Level mode external flag follows its pin.
// - Each source has a fixed ascending vector address.
// - High preempts low; high is never preempted.
// - All priorities are low after reset.
// - Higher level first, then lowest order wins.
// - Requests decoded every cycle, one detection cycle.
// - Equal or higher routine blocks until return plus one.
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tlv_irq_unit
  import tlv_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              NRST,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic [NUM_SRC-1:0] SRC_SET,
  input  wire logic              EXT_IRQ_PIN_0_N,
  input  wire logic              EXT_IRQ_PIN_1_N,
  input  wire logic              INSTR_DONE,
  input  wire logic              RETURN_FROM_IRQ_OP_DONE,
  output logic                   IRQ_REQ,
  output logic      [15:0]       IRQ_VECTOR,
  output logic                   IRQ_HIGH
);
  // Register state.
  logic [NUM_SRC-1:0] irq_enable_reg;        // Per-source enables.
  logic               global_irq_enable_reg; // Master gate over all enables.
  logic [NUM_SRC-1:0] irq_priority_reg;      // One means high level.
  logic [NUM_SRC-1:0] pend_reg;              // Flags of the non-external sources.
  logic [1:0]         trig_type_reg;         // Edge select, bit 0 for input 0.
  logic [1:0]         in_svc_reg;            // Bit 1 high level, bit 0 low level.
  logic               hold_reg;              // Waiting out one instruction after a return.
  logic               ack_reg;               // Bus answer.
  logic [31:0]        rdata_reg;             // Bus read data.
  logic               req_reg;               // Request towards the core.
  logic [15:0]        vector_reg;            // Address for the long call.
  logic               win_hi_reg;            // Level of the held request.
  logic [IDX_W-1:0]   win_idx_reg;           // Order of the held request.

  // Next values.
  logic [NUM_SRC-1:0] irq_enable_next;
  logic               global_irq_enable_next;
  logic [NUM_SRC-1:0] irq_priority_next;
  logic [NUM_SRC-1:0] pend_next;
  logic [1:0]         trig_type_next;
  logic [1:0]         in_svc_next;
  logic               hold_next;
  logic               req_next;

  // Bus decode.
  logic               bus_req;     // A cycle waits for its answer.
  logic               bus_wr;      // A write is taken at this edge.
  logic               wr_enable;
  logic               wr_priority;
  logic               wr_pending;
  logic               wr_tctrl;
  logic [31:0]        enable_word;
  logic [31:0]        pending_word;
  logic [31:0]        tctrl_word;
  logic [31:0]        status_word;
  logic [31:0]        m_enable;
  logic [31:0]        m_priority;
  logic [31:0]        m_pending;
  logic [31:0]        m_tctrl;
  logic [31:0]        rd_mux;

  // Arbitration.
  logic               ext0_pending_flag;
  logic               ext1_pending_flag;
  logic [NUM_SRC-1:0] pend_all;    // All flags with the external ones in place.
  logic [NUM_SRC-1:0] en_pend;     // Flags that may raise a request.
  logic [NUM_SRC-1:0] hi_vec;
  logic [NUM_SRC-1:0] lo_vec;
  logic               hi_found;
  logic               lo_found;
  logic [IDX_W-1:0]   hi_idx;
  logic [IDX_W-1:0]   lo_idx;
  logic               pick_hi;
  logic               pick_lo;
  logic [IDX_W-1:0]   pick_idx;
  logic               take;        // The core vectors at this edge.
  logic [NUM_SRC-1:0] take_onehot; // Source being vectored to.
  logic [NUM_SRC-1:0] hw_clear;    // Flags cleared by this vectoring.
  logic [NUM_SRC-1:0] ext_mask;    // Positions owned by the external inputs.

  // The answer comes one cycle after the request and drops the cycle after.
  // Masking the request with ack keeps one held cycle from being taken twice.
  // The cost is one idle cycle between transfers while the master holds its strobe.
  assign bus_req     = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign bus_wr      = bus_req & WB_WE_I;
  assign wr_enable   = bus_wr & (WB_ADR_I == OFF_ENABLE);
  assign wr_priority = bus_wr & (WB_ADR_I == OFF_PRIORITY);
  assign wr_pending  = bus_wr & (WB_ADR_I == OFF_PENDING);
  assign wr_tctrl    = bus_wr & (WB_ADR_I == OFF_TIMER_CTRL);

  // Register images as software sees them; unused bits read zero.
  assign enable_word  = {global_irq_enable_reg, 9'h000, irq_enable_reg};
  assign pending_word = {10'h000, pend_all};
  assign tctrl_word   = {28'h0000000, ext1_pending_flag, trig_type_reg[1],
                         ext0_pending_flag, trig_type_reg[0]};
  assign status_word  = {29'h00000000, hold_reg, in_svc_reg};
  assign m_enable     = merge_sel(enable_word, WB_DAT_I, WB_SEL_I);
  assign m_priority   = merge_sel({10'h000, irq_priority_reg}, WB_DAT_I, WB_SEL_I);
  assign m_pending    = merge_sel(pending_word, WB_DAT_I, WB_SEL_I);
  assign m_tctrl      = merge_sel(tctrl_word, WB_DAT_I, WB_SEL_I);

  // Unmapped addresses still answer, with zero, so a stray access never hangs.
  assign rd_mux = (WB_ADR_I == OFF_ENABLE)     ? enable_word :
                  (WB_ADR_I == OFF_PRIORITY)   ? {10'h000, irq_priority_reg} :
                  (WB_ADR_I == OFF_PENDING)    ? pending_word :
                  (WB_ADR_I == OFF_TIMER_CTRL) ? tctrl_word :
                  (WB_ADR_I == OFF_STATUS)     ? status_word : 32'h00000000;

  // Software writes merge into the fields under the byte selects; each source has its own bit.
  assign irq_enable_next        = wr_enable ? m_enable[NUM_SRC-1:0] : irq_enable_reg;
  assign global_irq_enable_next = wr_enable ? m_enable[GLOBAL_EN_BIT] :
                                  global_irq_enable_reg;
  assign irq_priority_next      = wr_priority ? m_priority[NUM_SRC-1:0] :
                                  irq_priority_reg;
  assign trig_type_next         = wr_tctrl ? {m_tctrl[EXT1_TYPE_BIT], m_tctrl[EXT0_TYPE_BIT]} :
                                  trig_type_reg;

  // External flags live in their own cells and are reached through the timer control word.
  assign ext_mask = (NUM_SRC'(1) << EXT0_ORDER) | (NUM_SRC'(1) << EXT1_ORDER);
  always_comb begin
    pend_all             = pend_reg & ~ext_mask;
    pend_all[EXT0_ORDER] = ext0_pending_flag;
    pend_all[EXT1_ORDER] = ext1_pending_flag;
  end

  // Vectoring clears the flags marked for hardware clear, and through take_onehot the edge-mode external flags.
  assign take        = INSTR_DONE & req_reg;
  assign take_onehot = take ? (NUM_SRC'(1) << win_idx_reg) : '0;
  assign hw_clear    = take_onehot & HW_CLEAR_MASK;

  // A trigger sets the flag regardless of the enable and beats any clear.
  assign pend_next = ((wr_pending ? m_pending[NUM_SRC-1:0] : pend_reg) & ~hw_clear) |
                     (SRC_SET & ~ext_mask);

  // Two external input cells, active low, each with its own trigger type.
  tlv_ext_input u_ext0 (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .pin_n     (EXT_IRQ_PIN_0_N),
    .trig_edge (trig_type_reg[0]),
    .vec_clear (take_onehot[EXT0_ORDER]),
    .sw_wr     (wr_tctrl & WB_SEL_I[0]),
    .sw_val    (m_tctrl[EXT0_FLAG_BIT]),
    .flag      (ext0_pending_flag)
  );
  tlv_ext_input u_ext1 (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .pin_n     (EXT_IRQ_PIN_1_N),
    .trig_edge (trig_type_reg[1]),
    .vec_clear (take_onehot[EXT1_ORDER]),
    .sw_wr     (wr_tctrl & WB_SEL_I[0]),
    .sw_val    (m_tctrl[EXT1_FLAG_BIT]),
    .flag      (ext1_pending_flag)
  );

  // Only enabled flags under the global gate may compete.
  // The flags themselves keep latching while gated, so a later enable sees them.
  assign en_pend = pend_all & irq_enable_reg & {NUM_SRC{global_irq_enable_reg}};
  assign hi_vec  = en_pend & irq_priority_reg;
  assign lo_vec  = en_pend & ~irq_priority_reg;

  tlv_arbiter #(.N(NUM_SRC), .W(IDX_W)) u_arb_hi (
    .req_vec (hi_vec),
    .found   (hi_found),
    .win_idx (hi_idx)
  );
  tlv_arbiter #(.N(NUM_SRC), .W(IDX_W)) u_arb_lo (
    .req_vec (lo_vec),
    .found   (lo_found),
    .win_idx (lo_idx)
  );

  // High wins over low; a running high routine blocks all, a running low blocks low.
  // Two arbiters run side by side, so the level choice adds no extra cycle.
  assign pick_hi  = hi_found & ~in_svc_reg[1];
  assign pick_lo  = lo_found & ~pick_hi & (in_svc_reg == 2'h0);
  assign pick_idx = pick_hi ? hi_idx : lo_idx;

  // A return releases the highest active level and starts a one-instruction wait.
  always_comb begin
    in_svc_next = in_svc_reg;
    if (RETURN_FROM_IRQ_OP_DONE) begin
      if (in_svc_reg[1]) begin
        in_svc_next[1] = 1'b0;
      end else begin
        in_svc_next[0] = 1'b0;
      end
    end else if (take) begin
      in_svc_next[win_hi_reg] = 1'b1;
    end
  end

  // The instruction after a return must complete before any new vectoring.
  assign hold_next = RETURN_FROM_IRQ_OP_DONE | (hold_reg & ~INSTR_DONE);
  // The request drops at the edge it is taken, so one request never vectors twice.
  assign req_next  = (pick_hi | pick_lo) & ~take & ~hold_next & ~RETURN_FROM_IRQ_OP_DONE;

  // Bus slave flops.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? rd_mux : rdata_reg;
    end
  end

  // Configuration and flag flops; priorities start at the low level.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_enable_reg        <= ENABLE_RST;
      global_irq_enable_reg <= 1'b0;
      irq_priority_reg      <= PRIORITY_RST;
      pend_reg              <= PENDING_RST;
      trig_type_reg         <= TRIG_TYPE_RST;
    end else begin
      irq_enable_reg        <= irq_enable_next;
      global_irq_enable_reg <= global_irq_enable_next;
      irq_priority_reg      <= irq_priority_next;
      pend_reg              <= pend_next;
      trig_type_reg         <= trig_type_next;
    end
  end

  // Decode is registered every cycle: one cycle of detection before the core sees it.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      in_svc_reg  <= 2'h0;
      hold_reg    <= 1'b0;
      req_reg     <= 1'b0;
      vector_reg  <= RESET_VECTOR;
      win_hi_reg  <= 1'b0;
      win_idx_reg <= '0;
    end else begin
      in_svc_reg  <= in_svc_next;
      hold_reg    <= hold_next;
      req_reg     <= req_next;
      vector_reg  <= vector_of(pick_idx);
      win_hi_reg  <= pick_hi;
      win_idx_reg <= pick_idx;
    end
  end

  assign WB_ACK_O   = ack_reg;
  assign WB_DAT_O   = rdata_reg;
  assign IRQ_REQ    = req_reg;
  assign IRQ_VECTOR = vector_reg;
  assign IRQ_HIGH   = win_hi_reg;

  // Checks on the request towards the core.
  // The request is registered, so most checks look one cycle back at the
  // state that produced it.  A request is never older than its cause by more
  // than one cycle, which keeps these checks free of long delays.
  // The in-service markers and the hold flag are the only memory of the past
  // that arbitration uses; the checks below watch each of them.
  // A vectoring edge drops the request and, unless a return falls on the same edge, sets a marker.
  // A return edge both clears a marker and starts the one-instruction wait.

  AST_GLOBAL_BLOCKS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !global_irq_enable_reg |=> !IRQ_REQ)
    else $error("Request raised with the global enable off.");
  AST_DISABLED_IGNORED: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    IRQ_REQ |-> ($past(en_pend) != '0))
    else $error("Request raised with no enabled flag.");
  AST_HIGH_NOT_PREEMPTED: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    in_svc_reg[1] |=> !IRQ_REQ)
    else $error("Request raised during a high level routine.");
  AST_LOW_ONLY_BY_HIGH: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ($past(in_svc_reg[0]) && IRQ_REQ) |-> IRQ_HIGH)
    else $error("Low request preempted a low level routine.");
  AST_VECTOR_MAP: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    IRQ_REQ |-> (IRQ_VECTOR == VECTOR_BASE + {8'h00, win_idx_reg, 3'h0}))
    else $error("Vector does not match the winning source.");
  AST_HIGH_FIRST: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (hi_found && lo_found && in_svc_reg == 2'h0 && !hold_next && !take && !RETURN_FROM_IRQ_OP_DONE)
    |=> (IRQ_REQ && IRQ_HIGH && win_idx_reg == $past(hi_idx)))
    else $error("Low level won over a high level request.");
  AST_RETURN_WAIT: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RETURN_FROM_IRQ_OP_DONE ##1 !INSTR_DONE |-> !IRQ_REQ ##1 !IRQ_REQ)
    else $error("Request raised before one instruction after return.");
  AST_HW_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (take && HW_CLEAR_MASK[win_idx_reg] && !SRC_SET[win_idx_reg] && !wr_pending)
    |=> !pend_all[$past(win_idx_reg)])
    else $error("Hardware cleared flag stayed set after vectoring.");
  AST_SW_FLAG_KEEPS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (take && !HW_CLEAR_MASK[win_idx_reg] && !ext_mask[win_idx_reg] && !wr_pending)
    |=> pend_all[$past(win_idx_reg)])
    else $error("Software cleared flag was cleared on vectoring.");
  AST_SET_WINS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ((SRC_SET & ~ext_mask) != '0) |=> ((pend_reg & $past(SRC_SET)) == ($past(SRC_SET) & ~ext_mask)))
    else $error("Trigger did not set its pending flag.");
  AST_IN_SERVICE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (take && !RETURN_FROM_IRQ_OP_DONE) |=> in_svc_reg[$past(win_hi_reg)])
    else $error("In-service marker not set on vectoring.");

  // A taken request must fall at once, or the core would vector twice.
  AST_TAKE_DROPS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    take |=> !IRQ_REQ)
    else $error("Request stood after it was taken.");

  // Every return starts the wait for one more instruction.
  AST_HOLD_AFTER_RETURN: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RETURN_FROM_IRQ_OP_DONE |=> hold_reg)
    else $error("No wait started after a return.");

  // A request always comes from a cycle in which the global gate was open.
  AST_GATE_OPEN: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    IRQ_REQ |-> $past(global_irq_enable_reg))
    else $error("Request raised from a closed global gate.");
endmodule : tlv_irq_unit
`default_nettype wire

// ==== shared/tlv_pkg.sv ====
`default_nettype none
package tlv_pkg;
  // Number of sources and the width of a source index.
  localparam int          NUM_SRC         = 22;
  localparam int          IDX_W           = 5;
  // Register byte offsets on the bus.
  localparam logic [7:0]  OFF_ENABLE      = 8'h00;
  localparam logic [7:0]  OFF_PRIORITY    = 8'h04;
  localparam logic [7:0]  OFF_PENDING     = 8'h08;
  localparam logic [7:0]  OFF_TIMER_CTRL  = 8'h0C;
  localparam logic [7:0]  OFF_STATUS      = 8'h10;
  // Field positions.
  localparam int          GLOBAL_EN_BIT   = 31;
  localparam int          EXT0_TYPE_BIT   = 0;
  localparam int          EXT0_FLAG_BIT   = 1;
  localparam int          EXT1_TYPE_BIT   = 2;
  localparam int          EXT1_FLAG_BIT   = 3;
  localparam int          STAT_SVC_LO_BIT = 0;
  localparam int          STAT_SVC_HI_BIT = 1;
  localparam int          STAT_HOLD_BIT   = 2;
  // Source orders of the two external inputs.
  localparam int          EXT0_ORDER      = 0;
  localparam int          EXT1_ORDER      = 2;
  // Reset values.
  localparam logic [21:0] ENABLE_RST      = 22'h000000;
  localparam logic [21:0] PRIORITY_RST    = 22'h000000;
  localparam logic [21:0] PENDING_RST     = 22'h000000;
  localparam logic [1:0]  TRIG_TYPE_RST   = 2'h0;
  // Flags that hardware clears on vectoring: timer 0, timer 1 and CAN.
  localparam logic [21:0] HW_CLEAR_MASK   = 22'h08000A;
  // Vector layout: reset at zero, sources at base plus eight per order.
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [15:0] VECTOR_BASE     = 16'h0003;

  // Fixed service address of the source with the given order.
  function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
    vector_of = VECTOR_BASE + {8'h00, idx, 3'h0};
  endfunction : vector_of

  // Merge write data into an old word under the byte selects.
  function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge_sel = (old_w & ~m) | (new_w & m);
  endfunction : merge_sel
endpackage : tlv_pkg
`default_nettype wire

// ==== testbench/tlv_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Core sequencer stand-in: completes one instruction every third cycle while run is high.
module tlv_core_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        do_return_from_irq_op,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  output logic             instr_done,
  output logic             return_from_irq_op_done,
  output logic [15:0]      taken_vec,
  output logic [7:0]       take_cnt,
  output logic [7:0]       gap
);
  logic [1:0] phase_reg; // Cycle position inside the current instruction.
  logic       ret_reg;   // A return is queued for the next completion.
  logic [7:0] cnt_reg;   // Instructions completed without a vectoring since the last return.
  wire        fin = run && (phase_reg == 2'h2);
  wire        take = instr_done && irq_req;
  // A vector is only taken at an instruction boundary, never mid-instruction.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 2'h0;
      ret_reg <= 1'b0;
      cnt_reg <= 8'h00;
      instr_done <= 1'b0;
      return_from_irq_op_done <= 1'b0;
      taken_vec <= 16'h0000;
      take_cnt <= 8'h00;
      gap <= 8'h00;
    end else begin
      phase_reg <= fin ? 2'h0 : phase_reg + {1'b0, run};
      ret_reg <= do_return_from_irq_op | (ret_reg & ~fin);
      instr_done <= fin & ~ret_reg;
      return_from_irq_op_done <= fin & ret_reg;
      cnt_reg <= return_from_irq_op_done ? 8'h00 : cnt_reg + {7'h00, instr_done & ~take};
      if (take) begin
        taken_vec <= irq_vector;
        take_cnt <= take_cnt + 8'h01;
        gap <= cnt_reg;
      end
    end
  end
endmodule : tlv_core_model
`default_nettype wire

// ==== testbench/tlv_irq_unit_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlv_irq_unit_bench;
  import tlv_pkg::*;
  logic        clk, nrst, cyc, stb, we, pin0_n, pin1_n, run, do_return_from_irq_op;
  logic [7:0]  adr;
  logic [31:0] dat_i, dat_o, q;
  logic [21:0] src_set;
  wire logic   ack, instr_done, return_from_irq_op_done, irq_req, irq_high;
  wire logic [15:0] irq_vector, taken_vec;
  wire logic [7:0]  take_cnt, gap;
  int          mismatches = 0;
  int          checked = 0;

  tlv_irq_unit uut (.SYS_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SRC_SET(src_set), .EXT_IRQ_PIN_0_N(pin0_n),
    .EXT_IRQ_PIN_1_N(pin1_n), .INSTR_DONE(instr_done), .RETURN_FROM_IRQ_OP_DONE(return_from_irq_op_done),
    .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_HIGH(irq_high));
  tlv_core_model core (.clk(clk), .nrst(nrst), .run(run), .do_return_from_irq_op(do_return_from_irq_op),
    .irq_req(irq_req), .irq_vector(irq_vector), .instr_done(instr_done),
    .return_from_irq_op_done(return_from_irq_op_done), .taken_vec(taken_vec), .take_cnt(take_cnt), .gap(gap));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Prints the verdict and stops the run.
  task automatic results();
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled high; a hung slave ends the run.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
    if (n >= 20) begin
      mismatches++;
      results();
    end
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic pulse(input int i);
    @(posedge clk);
    src_set[i] <= 1'b1;
    @(posedge clk);
    src_set <= 22'h0;
  endtask : pulse

  task automatic return_from_irq_op();
    @(posedge clk);
    do_return_from_irq_op <= 1'b1;
    @(posedge clk);
    do_return_from_irq_op <= 1'b0;
  endtask : return_from_irq_op

  // Waits for the core to have taken n vectors in total.
  task automatic take(input logic [7:0] n, input logic [15:0] v);
    int k;
    k = 0;
    run <= 1'b1;
    while (take_cnt !== n && k < 300) begin
      @(posedge clk);
      k++;
    end
    run <= 1'b0;
    if (k >= 300) begin
      mismatches++;
      results();
    end
    chk(taken_vec, v);
  endtask : take

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    idle(4);
    nrst <= 1'b1;
  endtask : do_reset

  initial begin
    {nrst, cyc, stb, we, adr, dat_i, src_set} = '0;
    {pin0_n, pin1_n, run, do_return_from_irq_op} = 4'b1100;
    do_reset();
    rd(OFF_PRIORITY, 32'h0, 32'hFFFF_FFFF);
    rd(OFF_ENABLE, 32'h0, 32'hFFFF_FFFF);
    rd(OFF_PENDING, 32'h0, 32'hFFFF_FFFF);
    rd(OFF_TIMER_CTRL, 32'h0, 32'hF);
    rd(8'h14, 32'h0, 32'hFFFF_FFFF);
    // A disabled source still latches its flag but asks for nothing.
    pulse(5);
    rd(OFF_PENDING, 32'h20, 32'h3F_FFFF);
    wb(1'b1, OFF_ENABLE, 32'h0000_0020);
    idle(4);
    chk(irq_req, 1'b0);
    wb(1'b1, OFF_ENABLE, 32'h8000_0010);
    idle(4);
    chk(irq_req, 1'b0);
    wb(1'b1, OFF_ENABLE, 32'h8000_0020);
    idle(3);
    chk(irq_vector, 16'h002B);
    take(8'd1, 16'h002B);
    rd(OFF_PENDING, 32'h20, 32'h20);
    rd(OFF_STATUS, 32'h1, 32'h3);
    // Flag left set: re-entry only after one more instruction.
    return_from_irq_op();
    take(8'd2, 16'h002B);
    chk(gap, 8'd1);
    // High source preempts the low routine; a high routine is never preempted.
    wb(1'b1, OFF_PRIORITY, 32'h0000_0280);
    wb(1'b1, OFF_ENABLE, 32'h8000_02A0);
    pulse(7);
    take(8'd3, 16'h003B);
    rd(OFF_STATUS, 32'h3, 32'h3);
    pulse(9);
    run <= 1'b1;
    idle(30);
    chk(take_cnt, 8'd3);
    wb(1'b1, OFF_PENDING, 32'h0000_0220);
    return_from_irq_op();
    take(8'd4, 16'h004B);
    // Reset in mid-service clears the markers.
    do_reset();
    rd(OFF_STATUS, 32'h0, 32'h7);
    wb(1'b1, OFF_ENABLE, 32'h8000_0050);
    wb(1'b1, OFF_PENDING, 32'h0000_0050);
    idle(4);
    chk(irq_vector, 16'h0023);
    wb(1'b1, OFF_PRIORITY, 32'h0000_0040);
    idle(4);
    chk(irq_vector, 16'h0033);
    // Edge-mode input 0 and timer 1 are cleared on vectoring.
    do_reset();
    wb(1'b1, OFF_TIMER_CTRL, 32'h1);
    @(posedge clk) pin0_n <= 1'b0;
    @(posedge clk) pin0_n <= 1'b1;
    rd(OFF_TIMER_CTRL, 32'h3, 32'h3);
    pulse(3);
    wb(1'b1, OFF_ENABLE, 32'h8000_0009);
    take(8'd1, 16'h0003);
    rd(OFF_TIMER_CTRL, 32'h1, 32'h3);
    return_from_irq_op();
    take(8'd2, 16'h001B);
    rd(OFF_PENDING, 32'h0, 32'h8);
    // Level-mode input 1 flag follows the pin; the source releases it itself.
    pin1_n <= 1'b0;
    idle(3);
    rd(OFF_TIMER_CTRL, 32'h8, 32'hC);
    pin1_n <= 1'b1;
    idle(3);
    rd(OFF_TIMER_CTRL, 32'h0, 32'hC);
    results();
  end
endmodule : tlv_irq_unit_bench
`default_nettype wire
